// [rtl/cmpev_pkg.sv]
// package: register map, field layout and mode codes for the comparator event block
`default_nettype none
package cmpev_pkg;
    localparam logic [7:0] ADDR_CTRL_A  = 8'h97;
    localparam logic [7:0] ADDR_CTRL_B  = 8'h9F;
    localparam logic [7:0] ADDR_SRC_SEL = 8'hAF;
    localparam logic [7:0] ADDR_STATUS  = 8'hB0;
    localparam logic [7:0] RST_CTRL_A   = 8'h00;
    localparam logic [7:0] RST_CTRL_B   = 8'hC0;
    localparam logic [7:0] RST_SRC_SEL  = 8'h00;
    localparam int         POS_SEL_LSB  = 6;
    localparam int         CONNECT_BIT  = 5;
    localparam int         FLAG_BIT     = 4;
    localparam int         ENABLE_BIT   = 3;
    localparam int         SRC_A_LSB    = 2;
    localparam int         SRC_B_LSB    = 6;
    localparam int         IE_CMP_BIT   = 6;
    localparam int         DEB_OVF_CNT  = 2;
    localparam int         FILT_SAMPLES = 4;
    localparam logic [1:0] SRC_SYSCLK   = 2'h0;
    localparam logic [1:0] SRC_TMR0     = 2'h1;
    localparam logic [1:0] SRC_TMR1     = 2'h2;
    localparam logic [1:0] SRC_TMR2     = 2'h3;
    localparam logic [2:0] MODE_LOW     = 3'h0;
    localparam logic [2:0] MODE_RISE    = 3'h1;
    localparam logic [2:0] MODE_TOG_DB  = 3'h2;
    localparam logic [2:0] MODE_RISE_DB = 3'h3;
    localparam logic [2:0] MODE_FALL    = 3'h4;
    localparam logic [2:0] MODE_TOG     = 3'h5;
    localparam logic [2:0] MODE_FALL_DB = 3'h6;
    localparam logic [2:0] MODE_HIGH    = 3'h7;

    typedef struct packed {
        logic [1:0] pos_sel;
        logic       connect;
        logic       flag;
        logic       enable;
        logic [2:0] mode;
    } cmpev_ctrl_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cmpev_bus_type;
endpackage
`default_nettype wire

// [rtl/cmpev_top.sv]
// comparator event detection, debounce and control/status registers
//
// Notes on behaviour
// - with system-clock source, sample each comparator output every cycle
// - debounce modes with system-clock source time resampling from timer 1 overflows
// - after a relevant transition, wait two timer 1 overflows before resampling
// - set flag if delayed sample matches expected level, else drop event
// - debounced flag rises one to two timer 1 periods after the edge
// - with timer source, a change counts as edge after 4 equal samples
// - connect bit one attaches analog pins, zero detaches them
// - flag set when mode condition met, stays until software clears it
// - interrupt request gated by bit 6 of interrupt-enable register
// - enable low forces comparator output low and blocks new flag sets
// - enable high puts the four shared analog pins in input-only mode
// - modes 000 low, 001 rise, 100 fall, 101 toggle, 111 high
// - modes 010 toggle, 011 rise, 110 fall, all debounced
// - debounce modes rely on timer 1 running; software keeps it running
// - control A: select 7:6, connect 5, flag 4, enable 3, mode 2:0, reset 00
// - control B same layout, reset C0; not bit addressable
// - per-comparator source select: system clock or timer 0/1/2 overflow
// - comparator output one when positive input exceeds negative
// - both comparators drive one shared interrupt request
`default_nettype none
module cmpev_top (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [1:0] cmp_raw,
    input  wire logic       tmr0_ovf,
    input  wire logic       tmr1_ovf,
    input  wire logic       tmr2_ovf,
    input  wire logic       interrupt_enable_register_bit,
    output logic            cmp_irq,
    output logic      [1:0] cmp_out,
    output logic      [1:0] input_connect,
    output logic      [3:0] positive_select,
    output logic            pins_input_only
);
    //////////////////////////////////////////////////////////////////////////
    // register bus and control registers
    cmpev_pkg::cmpev_bus_type  bus;
    cmpev_pkg::cmpev_ctrl_type ctrl_r [2];
    logic [7:0]                src_sel_r;
    logic [1:0]                flag_set;
    logic [1:0]                mode_wr;
    logic [1:0]                ctrl_wr;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign ctrl_wr[0] = bus.wr && bus.addr == cmpev_pkg::ADDR_CTRL_A;
    assign ctrl_wr[1] = bus.wr && bus.addr == cmpev_pkg::ADDR_CTRL_B;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r[0] <= cmpev_pkg::RST_CTRL_A;
            ctrl_r[1] <= cmpev_pkg::RST_CTRL_B;
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                if (ctrl_wr[i]) begin
                    ctrl_r[i] <= bus.wdata;
                end
                // hardware set wins over a software clear in the same cycle
                if (flag_set[i]) begin
                    ctrl_r[i].flag <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            src_sel_r <= cmpev_pkg::RST_SRC_SEL;
        end else if (clk_en && bus.wr && bus.addr == cmpev_pkg::ADDR_SRC_SEL) begin
            src_sel_r <= bus.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (bus.rd) begin
                unique case (bus.addr)
                    cmpev_pkg::ADDR_CTRL_A:  reg_rdata <= ctrl_r[0];
                    cmpev_pkg::ADDR_CTRL_B:  reg_rdata <= ctrl_r[1];
                    cmpev_pkg::ADDR_SRC_SEL: reg_rdata <= src_sel_r;
                    cmpev_pkg::ADDR_STATUS:  reg_rdata <= {6'h00, cmp_out};
                    default:                 reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // per-comparator event logic
    for (genvar g = 0; g < 2; g++) begin : g_cmp
        typedef enum logic [1:0] {
            DB_IDLE,
            DB_WAIT
        } cmpev_db_type;

        logic [1:0]   src;
        logic         sample_en;
        logic         out_lvl;
        logic         smp_r;
        logic         prev_r;
        logic [2:0]   stab_cnt_r;
        logic         rise;
        logic         fall;
        logic         debounced;
        logic         cond;
        cmpev_db_type db_state_r;
        logic [1:0]   ovf_cnt_r;
        logic         expect_r;

        assign src = (g == 0) ? src_sel_r[cmpev_pkg::SRC_A_LSB +: 2]
                              : src_sel_r[cmpev_pkg::SRC_B_LSB +: 2];
        assign mode_wr[g] = ctrl_wr[g] && bus.wdata[2:0] != ctrl_r[g].mode;
        assign out_lvl = ctrl_r[g].enable & cmp_raw[g];
        assign cmp_out[g] = smp_r;

        always_comb begin
            unique case (src)
                cmpev_pkg::SRC_SYSCLK: sample_en = 1'b1;
                cmpev_pkg::SRC_TMR0:   sample_en = tmr0_ovf;
                cmpev_pkg::SRC_TMR1:   sample_en = tmr1_ovf;
                cmpev_pkg::SRC_TMR2:   sample_en = tmr2_ovf;
            endcase
        end

        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                smp_r <= 1'b0;
            end else if (clk_en && sample_en) begin
                smp_r <= out_lvl;
            end
        end

        // timer sources: accepted level changes only after four equal samples
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                prev_r     <= 1'b0;
                stab_cnt_r <= 3'h0;
            end else if (clk_en) begin
                if (src == cmpev_pkg::SRC_SYSCLK) begin
                    prev_r     <= smp_r;
                    stab_cnt_r <= 3'h0;
                end else if (sample_en) begin
                    if (out_lvl == prev_r) begin
                        stab_cnt_r <= 3'h0;
                    end else if (stab_cnt_r == 3'(cmpev_pkg::FILT_SAMPLES - 1)) begin
                        prev_r     <= out_lvl;
                        stab_cnt_r <= 3'h0;
                    end else begin
                        stab_cnt_r <= stab_cnt_r + 3'h1;
                    end
                end
            end
        end

        assign rise = (src == cmpev_pkg::SRC_SYSCLK) ? (smp_r & ~prev_r)
                    : (sample_en && out_lvl && !prev_r
                       && stab_cnt_r == 3'(cmpev_pkg::FILT_SAMPLES - 1));
        assign fall = (src == cmpev_pkg::SRC_SYSCLK) ? (~smp_r & prev_r)
                    : (sample_en && !out_lvl && prev_r
                       && stab_cnt_r == 3'(cmpev_pkg::FILT_SAMPLES - 1));
        assign debounced = ctrl_r[g].mode == cmpev_pkg::MODE_TOG_DB
                        || ctrl_r[g].mode == cmpev_pkg::MODE_RISE_DB
                        || ctrl_r[g].mode == cmpev_pkg::MODE_FALL_DB;

        always_comb begin
            unique case (ctrl_r[g].mode)
                cmpev_pkg::MODE_LOW:  cond = sample_en & ~smp_r;
                cmpev_pkg::MODE_RISE: cond = rise;
                cmpev_pkg::MODE_FALL: cond = fall;
                cmpev_pkg::MODE_TOG:  cond = rise | fall;
                cmpev_pkg::MODE_HIGH: cond = sample_en & smp_r;
                default:              cond = 1'b0;
            endcase
        end

        // debounce: wait two timer 1 overflows, then compare with expected level
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                db_state_r <= DB_IDLE;
                ovf_cnt_r  <= 2'h0;
                expect_r   <= 1'b0;
            end else if (clk_en) begin
                if (!ctrl_r[g].enable || mode_wr[g]) begin
                    db_state_r <= DB_IDLE;
                    ovf_cnt_r  <= 2'h0;
                end else begin
                    unique case (db_state_r)
                        DB_IDLE: begin
                            if ((ctrl_r[g].mode == cmpev_pkg::MODE_RISE_DB && rise)
                                || (ctrl_r[g].mode == cmpev_pkg::MODE_FALL_DB && fall)
                                || (ctrl_r[g].mode == cmpev_pkg::MODE_TOG_DB && (rise | fall))) begin
                                db_state_r <= DB_WAIT;
                                ovf_cnt_r  <= 2'h0;
                                expect_r   <= rise;
                            end
                        end
                        DB_WAIT: begin
                            if (tmr1_ovf) begin
                                if (ovf_cnt_r == 2'(cmpev_pkg::DEB_OVF_CNT - 1)) begin
                                    db_state_r <= DB_IDLE;
                                end else begin
                                    ovf_cnt_r <= ovf_cnt_r + 2'h1;
                                end
                            end
                        end
                    endcase
                end
            end
        end

        assign flag_set[g] = ctrl_r[g].enable && (debounced
            ? (db_state_r == DB_WAIT && tmr1_ovf && !mode_wr[g]
               && ovf_cnt_r == 2'(cmpev_pkg::DEB_OVF_CNT - 1) && out_lvl == expect_r)
            : cond);
    end

    //////////////////////////////////////////////////////////////////////////
    // pins and shared interrupt
    assign input_connect   = {ctrl_r[1].connect, ctrl_r[0].connect};
    assign positive_select = {ctrl_r[1].pos_sel, ctrl_r[0].pos_sel};
    assign pins_input_only = ctrl_r[0].enable | ctrl_r[1].enable;
    assign cmp_irq = interrupt_enable_register_bit
                   & (ctrl_r[0].flag | ctrl_r[1].flag);
endmodule
`default_nettype wire

// [verification/cmpev_partner.sv]
// partner: comparator outputs and free-running timer overflow pulses
`default_nettype none
module cmpev_partner #(
    parameter int T0_PER = 5,
    parameter int T1_PER = 8,
    parameter int T2_PER = 7
) (
    input  wire logic       sys_clk,
    input  wire logic [1:0] cmp_level,
    output logic      [1:0] cmp_raw,
    output logic            tmr0_ovf,
    output logic            tmr1_ovf,
    output logic            tmr2_ovf
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    always @(posedge sys_clk) cnt <= cnt + 1;
    assign tmr0_ovf = (cnt % T0_PER) == 0;
    assign tmr1_ovf = (cnt % T1_PER) == 0;
    assign tmr2_ovf = (cnt % T2_PER) == 0;
    assign cmp_raw = cmp_level;
endmodule
`default_nettype wire

// [verification/cmpev_chk.sv]
// checker: port-level assertions for the comparator event block
`default_nettype none
module cmpev_chk (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       interrupt_enable_register_bit,
    input wire logic       cmp_irq,
    input wire logic [1:0] input_connect,
    input wire logic [3:0] positive_select,
    input wire logic       pins_input_only
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_wr_a; clk_en && reg_wr && reg_addr == 8'h97; endsequence
    sequence s_wr_b; clk_en && reg_wr && reg_addr == 8'h9F; endsequence
    sequence s_rd_bad; clk_en && reg_rd && !(reg_addr inside {8'h97, 8'h9F, 8'hAF, 8'hB0}); endsequence
    a_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero without a read");
    a_rd_unmapped: assert property (s_rd_bad |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_gate: assert property (!interrupt_enable_register_bit |-> !cmp_irq)
        else $error("irq high with enable low");
    a_conn_a: assert property (s_wr_a |=> input_connect[0] == $past(reg_wdata[5]))
        else $error("connect a not updated");
    a_sel_a: assert property (s_wr_a |=> positive_select[1:0] == $past(reg_wdata[7:6]))
        else $error("select a not updated");
    a_ctrl_b: assert property (s_wr_b |=> {positive_select[3:2], input_connect[1]} == $past(reg_wdata[7:5]))
        else $error("control b fields not updated");
    a_pins_only: assert property (s_wr_a ##0 reg_wdata[3] |=> pins_input_only)
        else $error("pins not input only while enabled");
    a_flag_hold: assert property (cmp_irq && !reg_wr ##1 interrupt_enable_register_bit |-> cmp_irq)
        else $error("flag dropped without software clear");
endmodule
bind cmpev_top cmpev_chk u_cmpev_chk (.sys_clk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .interrupt_enable_register_bit, .cmp_irq, .input_connect, .positive_select, .pins_input_only);
`default_nettype wire

// [verification/tb_cmpev_top.sv]
// testbench: register, event and debounce scenarios for the comparator block
`default_nettype none
module tb_cmpev_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       sys_clk, rstn, clk_en, reg_wr, reg_rd, ie, t0, t1, t2, rd_seen, irq, pins, s, db;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, r, sv;
    logic [1:0] lvl, raw, cmp_out, conn;
    logic [3:0] psel;
    logic [2:0] md;
    logic [7:0] exp_q[$];
    int         n_fail = 0, samples_checked = 0;
    cmpev_top u_cmpev_top (.sys_clk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .cmp_raw(raw), .tmr0_ovf(t0), .tmr1_ovf(t1), .tmr2_ovf(t2), .interrupt_enable_register_bit(ie),
        .cmp_irq(irq), .cmp_out, .input_connect(conn), .positive_select(psel), .pins_input_only(pins));
    cmpev_partner u_cmpev_partner (.sys_clk, .cmp_level(lvl), .cmp_raw(raw), .tmr0_ovf(t0), .tmr1_ovf(t1),
        .tmr2_ovf(t2));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] ca(input int c);
        return c ? 8'h9F : 8'h97;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic arm(input int c, input logic [2:0] m, input logic st);
        wr(ca(c), 8'h00);
        lvl[c] <= st;
        cyc(4);
        wr(ca(c), {5'h01, m});
        cyc(30);
        wr(ca(c), {5'h01, m});
        rd(ca(c), {5'h01, m});
    endtask
    task automatic stop_test;
        $display("compared %0d mismatched %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) rd_seen <= reg_rd;
    always @(negedge sys_clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
    end
    initial begin
        cyc(20000);
        n_fail++;
        stop_test();
    end
    initial begin
        rstn = 1'b0; clk_en = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
        ie = 1'b0; lvl = 2'h0; rd_seen = 1'b0;
        void'($urandom(32'hB82B));
        cyc(12);
        rstn <= 1'b1;
        ie   <= 1'b1;
        rd(8'h97, 8'h00);
        rd(8'h9F, 8'hC0);
        rd(8'hAF, 8'h00);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        for (int c = 0; c < 2; c++) begin
            r = $urandom;
            wr(ca(c), {r[2:1], 6'h00});
            wr(ca(c), {r[2:1], 6'h20});
            rd(ca(c), {r[2:1], 6'h20});
            for (int m = 0; m < 8; m++) begin
                md = m[2:0];
                s  = 8'h51 >> m;
                db = md[1] & ~(md[2] & md[0]);
                arm(c, md, s);
                lvl[c] <= ~s;
                cyc(3);
                rd(ca(c), {3'h0, ~db, 1'h1, md});
                cyc(24);
                rd(ca(c), {5'h03, md});
            end
            arm(c, 3'h3, 1'h0);
            lvl[c] <= 1'b1;
            cyc(2);
            lvl[c] <= 1'b0;
            cyc(24);
            rd(ca(c), 8'h0B);
            lvl[c] <= 1'b1;
            cyc(2);
            wr(ca(c), 8'h0E);
            cyc(24);
            rd(ca(c), 8'h0E);
            for (int k = 1; k < 4; k++) begin
                sv = {k[1:0], 2'h0, k[1:0], 2'h0};
                wr(8'hAF, sv);
                rd(8'hAF, sv);
                arm(c, 3'h1, 1'h0);
                lvl[c] <= 1'b1;
                cyc(8);
                lvl[c] <= 1'b0;
                cyc(40);
                rd(ca(c), 8'h09);
                lvl[c] <= 1'b1;
                cyc(48);
                rd(ca(c), 8'h19);
                @(negedge sys_clk);
                chk("cmp_irq", 8'h01, {7'h00, irq});
                @(posedge sys_clk);
                ie <= 1'b0;
                @(negedge sys_clk);
                chk("cmp_irq", 8'h00, {7'h00, irq});
                @(posedge sys_clk);
                ie <= 1'b1;
            end
            wr(8'hAF, 8'h00);
        end
        wr(8'h97, 8'h01);
        wr(8'h9F, 8'h01);
        lvl <= 2'h0;
        cyc(4);
        lvl <= 2'h3;
        cyc(4);
        rd(8'h97, 8'h01);
        rd(8'hB0, 8'h00);
        clk_en <= 1'b0;
        wr(8'h97, 8'hFF);
        clk_en <= 1'b1;
        rd(8'h97, 8'h01);
        ie <= 1'b0;
        cyc(4);
        stop_test();
    end
endmodule
`default_nettype wire
